/* File: hw/uirq_defines.svh */
// Offsets, field positions and reset values of the interrupt flag and mask
// registers. Assumes an 8-bit XDATA-style register port with 16-bit address.
`ifndef UIRQ_DEFINES_SVH
`define UIRQ_DEFINES_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define UIRQ_ADDR_IN_FLAGS 16'hDE02
`define UIRQ_ADDR_OUT_FLAGS 16'hDE04
`define UIRQ_ADDR_BUS_FLAGS 16'hDE06
`define UIRQ_ADDR_IN_EN 16'hDE07
`define UIRQ_ADDR_OUT_EN 16'hDE09
`define UIRQ_ADDR_BUS_EN 16'hDE0B
`define UIRQ_ADDR_FRAME_LO 16'hDE0C
`define UIRQ_ADDR_FRAME_HI 16'hDE0D
`define UIRQ_ADDR_EP_SEL 16'hDE0E

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UIRQ_BIT_SLEEP 0
`define UIRQ_BIT_WAKE 1
`define UIRQ_BIT_BUSRST 2
`define UIRQ_BIT_SOF 3
`define UIRQ_EP_MSB 5
`define UIRQ_BUS_MSB 3
`define UIRQ_SEL_MSB 3
`define UIRQ_FRAME_HI_MSB 2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define UIRQ_RST_IN_EN 8'h3F
`define UIRQ_RST_OUT_EN 8'h3E
`define UIRQ_RST_BUS_EN 4'h6
`define UIRQ_RST_EP_SEL 4'h0
`define UIRQ_RST_FLAGS 6'h00
`define UIRQ_RST_FRAME 11'h000

`endif

/* File: hw/uirq_pkg.sv */
// Types shared by the interrupt flag/mask block.
// Assumes the defines header is compiled alongside.
package uirq_pkg;

    typedef logic [7:0] uirq_byte_t;
    typedef logic [10:0] uirq_frame_t;

    // Register select decoded from the address
    typedef enum logic [9:0] {
        UIRQ_SEL_NONE = 10'h001,
        UIRQ_SEL_INF = 10'h002,
        UIRQ_SEL_OUTF = 10'h004,
        UIRQ_SEL_BUSF = 10'h008,
        UIRQ_SEL_INE = 10'h010,
        UIRQ_SEL_OUTE = 10'h020,
        UIRQ_SEL_BUSE = 10'h040,
        UIRQ_SEL_FRL = 10'h080,
        UIRQ_SEL_FRH = 10'h100,
        UIRQ_SEL_EPS = 10'h200
    } uirq_sel_e;

endpackage

/* File: hw/uirq_flag_if.sv */
// Carrier between the register block and its sticky flag bank.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface uirq_flag_if;
    logic [5:0] set;
    logic clr;
    logic [5:0] flags;

    modport owner (output set, output clr, input flags);
    modport bank (input set, input clr, output flags);
endinterface

/* File: hw/uirq_flag_bank.sv */
// Six sticky event flags, cleared together by a read of their register.
// Assumes set pulses and the clear strobe are synchronous to ref_clk_i.
`timescale 1ns/1ps
`include "uirq_defines.svh"
module uirq_flag_bank
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Flag carrier
    uirq_flag_if.bank fl
);

    logic [5:0] flag_q;

    // An event in the read cycle survives the clear
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_q <= `UIRQ_RST_FLAGS;
        else if (clk_en_i)
            flag_q <= (fl.clr ? 6'h00 : flag_q) | fl.set;
    end

    assign fl.flags = flag_q;

endmodule

/* File: hw/uirq_regs.sv */
// Interrupt flags, enable masks, frame number and endpoint select.
// Assumes an 8-bit register port, one access per cycle, 100 MHz clock.
`timescale 1ns/1ps
`include "uirq_defines.svh"
module uirq_regs
(
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Register port
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Events from packet engine and bus monitor, one-cycle pulses, and frame number
    input wire logic [5:0] in_ep_event_i,
    input wire logic [5:1] out_ep_event_i,
    input wire logic frame_start_i,
    input wire logic bus_reset_i,
    input wire logic bus_wake_i,
    input wire logic bus_sleep_i,
    input wire logic [10:0] frame_num_i,
    // Outputs to the rest of the controller
    output logic [3:0] endpoint_select_o,
    output logic summary_irq_pending_o
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic uirq_pkg::uirq_sel_e decode(input logic [15:0] a);
        case (a)
            `UIRQ_ADDR_IN_FLAGS: decode = uirq_pkg::UIRQ_SEL_INF;
            `UIRQ_ADDR_OUT_FLAGS: decode = uirq_pkg::UIRQ_SEL_OUTF;
            `UIRQ_ADDR_BUS_FLAGS: decode = uirq_pkg::UIRQ_SEL_BUSF;
            `UIRQ_ADDR_IN_EN: decode = uirq_pkg::UIRQ_SEL_INE;
            `UIRQ_ADDR_OUT_EN: decode = uirq_pkg::UIRQ_SEL_OUTE;
            `UIRQ_ADDR_BUS_EN: decode = uirq_pkg::UIRQ_SEL_BUSE;
            `UIRQ_ADDR_FRAME_LO: decode = uirq_pkg::UIRQ_SEL_FRL;
            `UIRQ_ADDR_FRAME_HI: decode = uirq_pkg::UIRQ_SEL_FRH;
            `UIRQ_ADDR_EP_SEL: decode = uirq_pkg::UIRQ_SEL_EPS;
            default: decode = uirq_pkg::UIRQ_SEL_NONE;
        endcase
    endfunction

    uirq_pkg::uirq_sel_e sel;
    logic rd_en;
    logic wr_en;

    assign sel = decode(reg_addr_i);
    assign rd_en = reg_rd_i && clk_en_i;
    assign wr_en = reg_wr_i && clk_en_i && !bus_reset_i;

    // ------------------------------------------------------------------
    // Register strobes
    // ------------------------------------------------------------------
    // One strobe per register keeps each always_ff free of decode terms
    logic bus_rst_now;
    logic clr_in_fl;
    logic clr_out_fl;
    logic clr_bus_fl;
    logic wr_in_en;
    logic wr_out_en;
    logic wr_bus_en;
    logic wr_ep_sel;

    assign bus_rst_now = clk_en_i && bus_reset_i;
    assign clr_in_fl = rd_en && (sel == uirq_pkg::UIRQ_SEL_INF);
    assign clr_out_fl = rd_en && (sel == uirq_pkg::UIRQ_SEL_OUTF);
    assign clr_bus_fl = rd_en && (sel == uirq_pkg::UIRQ_SEL_BUSF);
    assign wr_in_en = wr_en && (sel == uirq_pkg::UIRQ_SEL_INE);
    assign wr_out_en = wr_en && (sel == uirq_pkg::UIRQ_SEL_OUTE);
    assign wr_bus_en = wr_en && (sel == uirq_pkg::UIRQ_SEL_BUSE);
    assign wr_ep_sel = wr_en && (sel == uirq_pkg::UIRQ_SEL_EPS);

    // ------------------------------------------------------------------
    // Sticky flag banks
    // ------------------------------------------------------------------
    uirq_flag_if in_fl ();
    uirq_flag_if out_fl ();
    uirq_flag_if bus_fl ();

    assign in_fl.set = in_ep_event_i;
    assign in_fl.clr = clr_in_fl;

    // Bit 0 has no source, so it stays zero
    assign out_fl.set = {out_ep_event_i, 1'b0};
    assign out_fl.clr = clr_out_fl;

    assign bus_fl.set = {2'b00, frame_start_i, bus_reset_i,
                         bus_wake_i, bus_sleep_i};
    assign bus_fl.clr = clr_bus_fl;

    uirq_flag_bank u_in_bank
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .fl(in_fl)
    );

    uirq_flag_bank u_out_bank
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .fl(out_fl)
    );

    uirq_flag_bank u_bus_bank
    (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .clk_en_i(clk_en_i),
        .fl(bus_fl)
    );

    // ------------------------------------------------------------------
    // Enable masks
    // ------------------------------------------------------------------
    // Bits 7:6 of in_en and out_en are stored as written; software keeps them zero
    logic [7:0] in_en;
    logic [7:0] out_en;
    logic [3:0] bus_en;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            in_en <= `UIRQ_RST_IN_EN;
        end
        else if (bus_rst_now)
        begin
            in_en[5:0] <= 6'h3F;
        end
        else if (wr_in_en)
        begin
            in_en <= reg_wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            out_en <= `UIRQ_RST_OUT_EN;
        end
        else if (bus_rst_now)
        begin
            out_en[5:1] <= 5'h1F;
        end
        else if (wr_out_en)
        begin
            out_en <= {reg_wdata_i[7:1], 1'b0};
        end
    end

    // Bus reset forces reset and resume enables on, leaves SOF and suspend
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            bus_en <= `UIRQ_RST_BUS_EN;
        end
        else if (bus_rst_now)
        begin
            bus_en[`UIRQ_BIT_BUSRST] <= 1'b1;
            bus_en[`UIRQ_BIT_WAKE] <= 1'b1;
        end
        else if (wr_bus_en)
        begin
            bus_en <= reg_wdata_i[`UIRQ_BUS_MSB:0];
        end
    end

    // ------------------------------------------------------------------
    // Endpoint select
    // ------------------------------------------------------------------
    logic [3:0] ep_sel;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            ep_sel <= `UIRQ_RST_EP_SEL;
        end
        else if (bus_rst_now)
        begin
            ep_sel <= `UIRQ_RST_EP_SEL;
        end
        else if (wr_ep_sel)
        begin
            ep_sel <= reg_wdata_i[`UIRQ_SEL_MSB:0];
        end
    end

    // Indexed endpoint registers elsewhere decode this value directly
    assign endpoint_select_o = ep_sel;

    // ------------------------------------------------------------------
    // Frame number
    // ------------------------------------------------------------------
    uirq_pkg::uirq_frame_t frame;

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            frame <= `UIRQ_RST_FRAME;
        end
        else if (clk_en_i)
        begin
            frame <= frame_num_i;
        end
    end

    // ------------------------------------------------------------------
    // Summary interrupt
    // ------------------------------------------------------------------
    // True when any flag of a group has its enable bit set
    function automatic logic masked_any(input logic [5:0] flags,
                                        input logic [5:0] enables);
        masked_any = |(flags & enables);
    endfunction

    logic in_pend;
    logic out_pend;
    logic bus_pend;
    logic next_summary;

    assign in_pend = masked_any(in_fl.flags, in_en[5:0]);
    assign out_pend = masked_any(out_fl.flags, out_en[5:0]);
    assign bus_pend = masked_any(bus_fl.flags, {2'b00, bus_en});
    assign next_summary = in_pend || out_pend || bus_pend;

    // Registered so it stands clear of decode glitches
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            summary_irq_pending_o <= 1'b0;
        end
        else if (clk_en_i)
        begin
            summary_irq_pending_o <= next_summary;
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Registered read data: value of the cycle the read was presented
    uirq_pkg::uirq_byte_t next_rdata;

    always_comb
    begin
        case (sel)
            uirq_pkg::UIRQ_SEL_INF:
            begin
                next_rdata = {2'b00, in_fl.flags};
            end
            uirq_pkg::UIRQ_SEL_OUTF:
            begin
                next_rdata = {2'b00, out_fl.flags[5:1], 1'b0};
            end
            uirq_pkg::UIRQ_SEL_BUSF:
            begin
                next_rdata = {4'h0, bus_fl.flags[3:0]};
            end
            uirq_pkg::UIRQ_SEL_INE:
            begin
                next_rdata = in_en;
            end
            uirq_pkg::UIRQ_SEL_OUTE:
            begin
                next_rdata = {out_en[7:1], 1'b0};
            end
            uirq_pkg::UIRQ_SEL_BUSE:
            begin
                next_rdata = {4'h0, bus_en};
            end
            uirq_pkg::UIRQ_SEL_FRL:
            begin
                next_rdata = frame[7:0];
            end
            uirq_pkg::UIRQ_SEL_FRH:
            begin
                next_rdata = {5'h00, frame[10:8]};
            end
            uirq_pkg::UIRQ_SEL_EPS:
            begin
                next_rdata = {4'h0, ep_sel};
            end
            default:
            begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (rd_en)
        begin
            reg_rdata_o <= next_rdata;
        end
    end

endmodule

/* File: testbench/uirq_checker.sv */
// Assertions on the interrupt flag and mask register block.
// Assumes it is bound to uirq_regs and sees only its ports.
`timescale 1ns/1ps
`include "uirq_defines.svh"
module uirq_checker
(
    // Watched ports
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic [15:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic [5:0] in_ep_event_i,
    input wire logic [5:1] out_ep_event_i,
    input wire logic frame_start_i,
    input wire logic bus_reset_i,
    input wire logic bus_wake_i,
    input wire logic bus_sleep_i,
    input wire logic [10:0] frame_num_i,
    input wire logic [3:0] endpoint_select_o,
    input wire logic summary_irq_pending_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    wire logic rd = reg_rd_i && clk_en_i;
    wire logic bus_ev = frame_start_i | bus_reset_i | bus_wake_i | bus_sleep_i;
    wire logic any_ev = bus_ev | (|in_ep_event_i) | (|out_ep_event_i);
    wire logic [3:0] sel_wd = reg_wdata_i[3:0];
    logic [10:0] fr_q;
    // ----------------------------------------------------------------
    // Helper
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk_i)
    begin
        fr_q <= frame_num_i;
    end
    sequence s_bus_rd;
        rd && reg_addr_i == `UIRQ_ADDR_BUS_FLAGS;
    endsequence
    sequence s_quiet_rd;
        s_bus_rd ##0 !bus_ev;
    endsequence
    property p_sof_kept;
        frame_start_i ##0 s_bus_rd ##1 s_bus_rd |=> reg_rdata_o[3];
    endproperty
    property p_bus_clr;
        s_quiet_rd ##1 s_quiet_rd |=> reg_rdata_o == 8'h00;
    endproperty
    property p_ep_rsvd;
        rd && reg_addr_i inside {`UIRQ_ADDR_IN_FLAGS, `UIRQ_ADDR_OUT_FLAGS}
            |=> reg_rdata_o[7:6] == 2'h0;
    endproperty
    property p_out_b0;
        rd && reg_addr_i inside {`UIRQ_ADDR_OUT_FLAGS, `UIRQ_ADDR_OUT_EN}
            |=> !reg_rdata_o[0];
    endproperty
    property p_frl;
        rd && reg_addr_i == `UIRQ_ADDR_FRAME_LO && $stable(frame_num_i)
            && $past(rst_n_i) |=> reg_rdata_o == fr_q[7:0];
    endproperty
    property p_frh;
        rd && reg_addr_i == `UIRQ_ADDR_FRAME_HI && $stable(frame_num_i)
            && $past(rst_n_i) |=> reg_rdata_o == {5'h00, fr_q[10:8]};
    endproperty
    property p_sel_wr;
        reg_wr_i && clk_en_i && reg_addr_i == `UIRQ_ADDR_EP_SEL && !bus_reset_i
            |=> endpoint_select_o == $past(sel_wd);
    endproperty
    property p_sel_rst;
        clk_en_i && bus_reset_i |=> endpoint_select_o == 4'h0;
    endproperty
    property p_sum_rise;
        $rose(summary_irq_pending_o) |-> $past(any_ev || reg_wr_i, 2);
    endproperty
    property p_sum_fall;
        $fell(summary_irq_pending_o)
            |-> $past(reg_rd_i || reg_wr_i || bus_reset_i, 2);
    endproperty
    a_sof_kept: assert property (p_sof_kept) else $error("flag lost");
    a_bus_clr: assert property (p_bus_clr) else $error("no clear");
    a_ep_rsvd: assert property (p_ep_rsvd) else $error("bits 7:6");
    a_out_b0: assert property (p_out_b0) else $error("out bit 0");
    a_frl: assert property (p_frl) else $error("frame low");
    a_frh: assert property (p_frh) else $error("frame high");
    a_sel_wr: assert property (p_sel_wr) else $error("select wr");
    a_sel_rst: assert property (p_sel_rst) else $error("select rst");
    a_sum_rise: assert property (p_sum_rise) else $error("irq rise");
    a_sum_fall: assert property (p_sum_fall) else $error("irq fall");
endmodule

/* File: testbench/uirq_evt_src.sv */
// Stand-in for the packet engine and bus monitor that raise events.
// Assumes the bench calls its tasks; outputs move at falling edges.
`timescale 1ns/1ps
module uirq_evt_src
(
    // Clock
    input wire logic ref_clk_i,
    // Events and frame number
    output logic [5:0] in_ep_o,
    output logic [5:1] out_ep_o,
    output logic [3:0] bus_o,
    output logic [10:0] frame_o
);
    initial
    begin
        {bus_o, out_ep_o, in_ep_o} = 15'h0000;
        frame_o = 11'h000;
    end
    // One-cycle pulses; a frame start also advances the 11-bit count
    task automatic pulse(input logic [14:0] m);
        @(negedge ref_clk_i);
        {bus_o, out_ep_o, in_ep_o} = m;
        if (m[14])
            frame_o = frame_o + 11'h001;
        @(negedge ref_clk_i);
        {bus_o, out_ep_o, in_ep_o} = 15'h0000;
    endtask
    task automatic set_frame(input logic [10:0] v);
        @(negedge ref_clk_i);
        frame_o = v;
    endtask
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the interrupt flag and mask register block.
// Assumes the event source model and the checker are compiled with it.
`timescale 1ns/1ps
`include "uirq_defines.svh"
module tb_top;
    logic clk;
    logic rst_n;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic en = 1'b1;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [5:0] in_ev;
    logic [5:1] out_ev;
    logic [3:0] bus_ev;
    logic [10:0] frame;
    logic [3:0] sel;
    logic irq;
    logic [15:0] a;
    logic [3:0] bus_rst = 4'h6;
    int b;
    int fail_count = 0;
    int n_checks = 0;
    uirq_regs i_uirq_regs (.ref_clk_i(clk), .rst_n_i(rst_n), .clk_en_i(en),
        .reg_addr_i(addr), .reg_rd_i(rd), .reg_wr_i(wr), .reg_wdata_i(wdata),
        .reg_rdata_o(rdata), .in_ep_event_i(in_ev), .out_ep_event_i(out_ev),
        .frame_start_i(bus_ev[3]), .bus_reset_i(bus_ev[2]),
        .bus_wake_i(bus_ev[1]), .bus_sleep_i(bus_ev[0]), .frame_num_i(frame),
        .endpoint_select_o(sel), .summary_irq_pending_o(irq));
    uirq_evt_src i_uirq_evt_src (.ref_clk_i(clk), .in_ep_o(in_ev),
        .out_ep_o(out_ev), .bus_o(bus_ev), .frame_o(frame));
    // ----------------------------------------------------------------
    // Access tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [15:0] ad, input logic [7:0] d);
        @(negedge clk);
        addr = ad;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // Two reads on consecutive edges when e2 is given
    task automatic rd_chk(input logic [15:0] ad, input logic [7:0] e1,
        input logic [8:0] e2 = 9'h100);
        @(negedge clk);
        addr = ad;
        rd = 1'b1;
        @(negedge clk);
        chk(rdata, e1);
        if (!e2[8])
        begin
            @(negedge clk);
            chk(rdata, e2[7:0]);
        end
        rd = 1'b0;
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200us;
        fail_count++;
        summarize();
    end
    initial
    begin
        rst_n = 1'b0;
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;
        rd_chk(`UIRQ_ADDR_IN_EN, 8'h3F);
        rd_chk(`UIRQ_ADDR_OUT_EN, 8'h3E);
        rd_chk(`UIRQ_ADDR_BUS_EN, 8'h06);
        rd_chk(`UIRQ_ADDR_FRAME_LO, 8'h00);
        rd_chk(`UIRQ_ADDR_FRAME_HI, 8'h00);
        rd_chk(`UIRQ_ADDR_EP_SEL, 8'h00);
        rd_chk(16'hDE03, 8'h00);
        for (int i = 0; i < 15; i++)
        begin
            a = i < 6 ? `UIRQ_ADDR_IN_FLAGS : i < 11 ? `UIRQ_ADDR_OUT_FLAGS
                : `UIRQ_ADDR_BUS_FLAGS;
            b = i < 6 ? i : i < 11 ? i - 5 : i - 11;
            i_uirq_evt_src.pulse(15'h0001 << i);
            @(negedge clk);
            chk({7'h00, irq}, {7'h00, i < 11 || bus_rst[b]});
            rd_chk(a, 8'h01 << b, 9'h000);
            chk({7'h00, irq}, 8'h00);
        end
        wr_reg(`UIRQ_ADDR_IN_EN, 8'h00);
        i_uirq_evt_src.pulse(15'h0008);
        repeat (2) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        wr_reg(`UIRQ_ADDR_IN_EN, 8'h08);
        @(negedge clk);
        chk({7'h00, irq}, 8'h01);
        rd_chk(`UIRQ_ADDR_IN_EN, 8'h08);
        wr_reg(`UIRQ_ADDR_IN_FLAGS, 8'hFF);
        rd_chk(`UIRQ_ADDR_IN_FLAGS, 8'h08, 9'h000);
        wr_reg(`UIRQ_ADDR_OUT_EN, 8'h3F);
        rd_chk(`UIRQ_ADDR_OUT_EN, 8'h3E);
        wr_reg(`UIRQ_ADDR_BUS_EN, 8'h09);
        rd_chk(`UIRQ_ADDR_BUS_EN, 8'h09);
        for (int s = 0; s < 6; s++)
        begin
            wr_reg(`UIRQ_ADDR_EP_SEL, 8'(s));
            chk({4'h0, sel}, 8'(s));
        end
        rd_chk(`UIRQ_ADDR_EP_SEL, 8'h05);
        i_uirq_evt_src.pulse(15'h2000);
        rd_chk(`UIRQ_ADDR_EP_SEL, 8'h00);
        rd_chk(`UIRQ_ADDR_IN_EN, 8'h3F);
        rd_chk(`UIRQ_ADDR_BUS_EN, 8'h0F);
        rd_chk(`UIRQ_ADDR_BUS_FLAGS, 8'h04);
        fork
            i_uirq_evt_src.pulse(15'h4000);
            rd_chk(`UIRQ_ADDR_BUS_FLAGS, 8'h00, 9'h008);
        join
        rd_chk(`UIRQ_ADDR_BUS_FLAGS, 8'h00, 9'h000);
        i_uirq_evt_src.set_frame(11'h7FF);
        rd_chk(`UIRQ_ADDR_FRAME_LO, 8'hFF);
        rd_chk(`UIRQ_ADDR_FRAME_HI, 8'h07);
        i_uirq_evt_src.pulse(15'h4000);
        rd_chk(`UIRQ_ADDR_FRAME_LO, 8'h00);
        rd_chk(`UIRQ_ADDR_FRAME_HI, 8'h00);
        en = 1'b0;
        i_uirq_evt_src.pulse(15'h0002);
        en = 1'b1;
        rd_chk(`UIRQ_ADDR_IN_FLAGS, 8'h00);
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        rd_chk(`UIRQ_ADDR_BUS_EN, 8'h06);
        rd_chk(`UIRQ_ADDR_BUS_FLAGS, 8'h00);
        chk({7'h00, irq}, 8'h00);
        summarize();
    end
endmodule
bind uirq_regs uirq_checker i_uirq_checker (.ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i), .clk_en_i(clk_en_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .in_ep_event_i(in_ep_event_i),
    .out_ep_event_i(out_ep_event_i), .frame_start_i(frame_start_i),
    .bus_reset_i(bus_reset_i), .bus_wake_i(bus_wake_i),
    .bus_sleep_i(bus_sleep_i), .frame_num_i(frame_num_i),
    .endpoint_select_o(endpoint_select_o),
    .summary_irq_pending_o(summary_irq_pending_o));
